/* rtl/pie_pkg.sv */
// Purpose: Constants for the peripheral interrupt enable/priority block
// Assumes: 32-bit AXI4-Lite register bus, 8-bit registers in low lanes
// Notes: One line per rule below
// How it works
// - Enable bit 5 gates serial2 receive
// - Enable bit 4 gates serial2 transmit
// - Enable bits 2..0 gate capcmp 5,4,3
// - Three priority registers, one bit per source
// - Priority bits act only when levels on
// - Priority 1 high, 0 low; reset ones
// - Priority1 bits 7..4: parport, converter, serial1
// - Priority1 bits 3..0: sync, capcmp1, timers
// - Parport priority only in microcontroller mode

package pie_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_ENABLE3 = 8'h00;
    localparam logic [7:0] ADDR_PRIO1 = 8'h04;
    localparam logic [7:0] ADDR_PRIO2 = 8'h08;
    localparam logic [7:0] ADDR_PRIO3 = 8'h0C;
    localparam logic [7:0] ADDR_CTRL = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_MASK = 8'h18;
    localparam logic [7:0] ADDR_PENDING = 8'h1C;

    // Writable bit masks; unimplemented bits read zero
    localparam logic [7:0] WMASK_ENABLE3 = 8'h3F;
    localparam logic [7:0] WMASK_PRIO1 = 8'hFF;
    localparam logic [7:0] WMASK_PRIO2 = 8'h5F;
    localparam logic [7:0] WMASK_PRIO3 = 8'h3F;
    localparam logic [7:0] WMASK_CTRL = 8'h03;
    localparam logic [7:0] WMASK_EVENT = 8'h03;

    // Reset values
    localparam logic [7:0] RST_ENABLE3 = 8'h00;
    localparam logic [7:0] RST_PRIO1 = 8'hFF;
    localparam logic [7:0] RST_PRIO2 = 8'h5F;
    localparam logic [7:0] RST_PRIO3 = 8'h3F;
    localparam logic [7:0] RST_CTRL = 8'h00;

    // Field positions
    localparam int CTRL_LEVELS_ON = 0;
    localparam int CTRL_MCU_MODE = 1;
    localparam int EVT_HIGH = 0;
    localparam int EVT_LOW = 1;
    localparam int PARPORT_BIT = 7;
    localparam int SRC_COUNT = 24;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pie_pkg

/* rtl/pie_irq_enable_priority.sv */
// Purpose: Peripheral interrupt enable 3 and priority 1..3 registers, with
//          request routing to high and low vectors and a summary interrupt
// Assumes: Flag and enable inputs are synchronous to mclk
// Notes: Single clock, synchronous reset, AXI4-Lite slave for registers
//        Unimplemented register bits are dropped on write and read as zero

`timescale 1ns/1ps
`default_nettype none

module pie_irq_enable_priority #(
    parameter int ADDR_W = 8 // Byte address width seen by the slave
) (
    input wire logic mclk, // Core clock, 50 MHz
    input wire logic srst, // Synchronous reset, active high
    // AXI4-Lite write address
    input wire logic awvalid, // Write address valid
    output logic awready, // Write address ready
    input wire logic [ADDR_W-1:0] awaddr, // Write byte address
    // AXI4-Lite write data
    input wire logic wvalid, // Write data valid
    output logic wready, // Write data ready
    input wire logic [31:0] wdata, // Write data
    input wire logic [3:0] wstrb, // Byte lane strobes
    // AXI4-Lite write response
    output logic bvalid, // Write response valid
    input wire logic bready, // Write response ready
    output logic [1:0] bresp, // Write response code
    // AXI4-Lite read address
    input wire logic arvalid, // Read address valid
    output logic arready, // Read address ready
    input wire logic [ADDR_W-1:0] araddr, // Read byte address
    // AXI4-Lite read data
    output logic rvalid, // Read data valid
    input wire logic rready, // Read data ready
    output logic [31:0] rdata, // Read data
    output logic [1:0] rresp, // Read response code
    // Interrupt sources
    input wire logic [7:0] prio1SrcFlag, // Flags of priority-1 sources
    input wire logic [7:0] prio1SrcEn, // Enables held elsewhere
    input wire logic [7:0] prio2SrcFlag, // Flags of priority-2 sources
    input wire logic [7:0] prio2SrcEn, // Enables held elsewhere
    input wire logic [7:0] enable3SrcFlag, // Flags of enable-3 sources
    // Results
    output logic [7:0] periphEnableReg3, // Enable register 3 contents
    output logic reqHigh, // Request to the high vector
    output logic reqLow, // Request to the low vector
    output logic irq // Summary interrupt, level
);

    ////////////////////////////////////////////////////////////////////////
    // State
    ////////////////////////////////////////////////////////////////////////

    // Whole module state in one packed record
    typedef struct packed {
        logic awRdy; // Address channel open
        logic wRdy; // Data channel open
        logic awHeld; // Write address captured
        logic [7:0] awAddr; // Captured write address
        logic wHeld; // Write data captured
        logic [7:0] wData; // Captured low data byte
        logic wLane0; // Captured strobe of lane 0
        logic bValid; // Response pending
        logic [1:0] bResp; // Response code
        logic arRdy; // Read address open
        logic rValid; // Read data pending
        logic [7:0] rData; // Read data byte
        logic [1:0] rResp; // Read response code
        logic [7:0] enable3; // Enable register 3
        logic [7:0] prio1; // Priority register 1
        logic [7:0] prio2; // Priority register 2
        logic [7:0] prio3; // Priority register 3
        logic [7:0] ctrl; // Levels-on and microcontroller mode
        logic [7:0] status; // Sticky vector events
        logic [7:0] mask; // Event mask
        logic reqHi; // Registered high request
        logic reqLo; // Registered low request
        logic irq; // Registered summary interrupt
    } pie_state_s;

    pie_state_s st; // Current state
    pie_state_s next_st; // Next state

    ////////////////////////////////////////////////////////////////////////
    // Request routing
    ////////////////////////////////////////////////////////////////////////

    logic [pie_pkg::SRC_COUNT-1:0] srcFlag; // All flags, 8 per group
    logic [pie_pkg::SRC_COUNT-1:0] srcEn; // All enables
    logic [pie_pkg::SRC_COUNT-1:0] srcPrio; // All priority bits
    logic [pie_pkg::SRC_COUNT-1:0] srcHigh; // Source wants high vector
    logic [pie_pkg::SRC_COUNT-1:0] srcLow; // Source wants low vector
    logic anyHigh; // Some source on high vector
    logic anyLow; // Some source on low vector

    // Bit order: group 1 lowest, then group 2, group 3 on top
    // Limitation: enables of groups 1 and 2 are kept outside this block
    // Group 3 enables live here, the rest arrive from outside
    assign srcFlag = {enable3SrcFlag, prio2SrcFlag, prio1SrcFlag};
    assign srcEn = {st.enable3, prio2SrcEn, prio1SrcEn};
    // Unimplemented priority bits are zero but their sources are absent too
    assign srcPrio = {st.prio3, st.prio2, st.prio1};

    // One cell per source; bit 7 of group 1 is the parallel port
    // Outside microcontroller mode that bit reads back but routes high
    genvar gi;
    generate
        for (gi = 0; gi < pie_pkg::SRC_COUNT; gi++) begin : g_src
            logic active; // Flag set and enabled
            logic hiPrio; // Effective priority
            assign active = srcFlag[gi] & srcEn[gi];
            if (gi == pie_pkg::PARPORT_BIT) begin : g_pp
                // Outside microcontroller mode the bit holds no sway
                assign hiPrio = srcPrio[gi] | ~st.ctrl[pie_pkg::CTRL_MCU_MODE];
            end else begin : g_plain
                assign hiPrio = srcPrio[gi];
            end
            // Without priority levels everything goes to the high vector
            assign srcHigh[gi] = active &
                (hiPrio | ~st.ctrl[pie_pkg::CTRL_LEVELS_ON]);
            assign srcLow[gi] = active & ~hiPrio &
                st.ctrl[pie_pkg::CTRL_LEVELS_ON];
        end
    endgenerate

    // Fold every source cell into the two vector requests
    assign anyHigh = |srcHigh;
    assign anyLow = |srcLow;

    ////////////////////////////////////////////////////////////////////////
    // Register access helpers
    ////////////////////////////////////////////////////////////////////////

    // Write a masked byte, leaving unimplemented bits zero
    function automatic logic [7:0] merge_byte(
        input logic [7:0] data,
        input logic [7:0] wmask
    );
        merge_byte = data & wmask;
    endfunction : merge_byte

    // Address is mapped when it hits one of the eight words
    // Unmapped words answer with an error and store nothing
    function automatic logic is_mapped(input logic [7:0] addr);
        case (addr)
            pie_pkg::ADDR_ENABLE3, pie_pkg::ADDR_PRIO1, pie_pkg::ADDR_PRIO2,
            pie_pkg::ADDR_PRIO3, pie_pkg::ADDR_CTRL, pie_pkg::ADDR_STATUS,
            pie_pkg::ADDR_MASK, pie_pkg::ADDR_PENDING: begin
                is_mapped = 1'b1;
            end
            default: begin
                is_mapped = 1'b0;
            end
        endcase
    endfunction : is_mapped

    ////////////////////////////////////////////////////////////////////////
    // Next state
    ////////////////////////////////////////////////////////////////////////

    logic doWrite; // Both halves of a write present
    logic doRead; // Read address taken this cycle
    logic [7:0] rAddr; // Low read address byte
    logic [7:0] statusClr; // Bits software clears
    logic [7:0] statusSet; // Bits hardware sets

    // Bus handshakes, register writes, routing and events
    always_comb begin
        next_st = st;
        statusClr = 8'h00;
        statusSet = 8'h00;
        rAddr = 8'(araddr);
        doWrite = st.awHeld & st.wHeld & ~st.bValid;
        doRead = arvalid & st.arRdy;

        // Capture write address and data in either order
        if (awvalid && st.awRdy) begin
            next_st.awHeld = 1'b1;
            next_st.awAddr = 8'(awaddr);
        end
        if (wvalid && st.wRdy) begin
            next_st.wHeld = 1'b1;
            next_st.wData = wdata[7:0];
            next_st.wLane0 = wstrb[0];
        end

        // Retire response once taken
        if (st.bValid && bready) begin
            next_st.bValid = 1'b0;
        end

        // Perform write once both halves are in
        // Held halves wait here while an older response is pending
        if (doWrite) begin
            next_st.awHeld = 1'b0;
            next_st.wHeld = 1'b0;
            next_st.bValid = 1'b1;
            next_st.bResp = is_mapped(st.awAddr) ? pie_pkg::RESP_OKAY
                                                 : pie_pkg::RESP_SLVERR;
            // Only lane 0 carries register bits
            // Each register keeps only its writable bits
            if (st.wLane0) begin
                case (st.awAddr)
                    pie_pkg::ADDR_ENABLE3: begin
                        next_st.enable3 = merge_byte(st.wData,
                            pie_pkg::WMASK_ENABLE3);
                    end
                    pie_pkg::ADDR_PRIO1: begin
                        next_st.prio1 = merge_byte(st.wData,
                            pie_pkg::WMASK_PRIO1);
                    end
                    pie_pkg::ADDR_PRIO2: begin
                        next_st.prio2 = merge_byte(st.wData, pie_pkg::WMASK_PRIO2);
                    end
                    pie_pkg::ADDR_PRIO3: begin
                        next_st.prio3 = merge_byte(st.wData, pie_pkg::WMASK_PRIO3);
                    end
                    pie_pkg::ADDR_CTRL: begin
                        next_st.ctrl = merge_byte(st.wData, pie_pkg::WMASK_CTRL);
                    end
                    pie_pkg::ADDR_STATUS: begin
                        // Write one to clear
                        statusClr = merge_byte(st.wData, pie_pkg::WMASK_EVENT);
                    end
                    pie_pkg::ADDR_MASK: begin
                        next_st.mask = merge_byte(st.wData, pie_pkg::WMASK_EVENT);
                    end
                    default: begin
                        // Read-only or unmapped: nothing stored
                    end
                endcase
            end
        end

        // Channels open only while nothing is captured
        // They may reopen while a response waits; the next write is then
        // captured but not performed until that response is taken
        next_st.awRdy = ~next_st.awHeld;
        next_st.wRdy = ~next_st.wHeld;

        // Read path, one read at a time
        // The read address is used live, since it is taken at once
        if (st.rValid && rready) begin
            next_st.rValid = 1'b0;
        end
        if (doRead) begin
            next_st.rValid = 1'b1;
            next_st.rResp = is_mapped(rAddr) ? pie_pkg::RESP_OKAY
                                             : pie_pkg::RESP_SLVERR;
            // Registers read as stored, before any write in this cycle
            case (rAddr)
                pie_pkg::ADDR_ENABLE3: begin
                    next_st.rData = st.enable3;
                end
                pie_pkg::ADDR_PRIO1: begin
                    next_st.rData = st.prio1;
                end
                pie_pkg::ADDR_PRIO2: begin
                    next_st.rData = st.prio2;
                end
                pie_pkg::ADDR_PRIO3: begin
                    next_st.rData = st.prio3;
                end
                pie_pkg::ADDR_CTRL: begin
                    next_st.rData = st.ctrl;
                end
                pie_pkg::ADDR_STATUS: begin
                    next_st.rData = st.status;
                end
                pie_pkg::ADDR_MASK: begin
                    next_st.rData = st.mask;
                end
                pie_pkg::ADDR_PENDING: begin
                    // Live vector state for polling software
                    next_st.rData = {6'h00, st.reqLo, st.reqHi};
                end
                default: begin
                    next_st.rData = 8'h00;
                end
            endcase
        end
        // A new read waits until the old data has been taken
        next_st.arRdy = ~next_st.rValid;

        // Vector requests, registered once
        next_st.reqHi = anyHigh;
        next_st.reqLo = anyLow;

        // Rising vector requests are the sticky events
        // Steady request levels are not events, only rising edges
        statusSet[pie_pkg::EVT_HIGH] = anyHigh & ~st.reqHi;
        statusSet[pie_pkg::EVT_LOW] = anyLow & ~st.reqLo;
        // A set in the clearing cycle wins
        next_st.status = (st.status & ~statusClr) | statusSet;

        // Summary output follows the stored bits
        // Built from next status and mask so no cycle is lost
        next_st.irq = |(next_st.status & next_st.mask);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    ////////////////////////////////////////////////////////////////////////

    // Synchronous reset to defined values
    // Bus channels come out closed and open one edge after release
    always_ff @(posedge mclk) begin
        if (srst) begin
            // Clear everything, then load the register defaults
            st <= '0;
            st.enable3 <= pie_pkg::RST_ENABLE3;
            st.prio1 <= pie_pkg::RST_PRIO1;
            st.prio2 <= pie_pkg::RST_PRIO2;
            st.prio3 <= pie_pkg::RST_PRIO3;
            st.ctrl <= pie_pkg::RST_CTRL;
            st.bResp <= pie_pkg::RESP_OKAY;
            st.rResp <= pie_pkg::RESP_OKAY;
        end else begin
            // All state moves together on every edge
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, each straight from a state bit
    ////////////////////////////////////////////////////////////////////////

    assign awready = st.awRdy;
    assign wready = st.wRdy;
    assign bvalid = st.bValid;
    assign bresp = st.bResp;
    assign arready = st.arRdy;
    assign rvalid = st.rValid;
    // Only the low byte of read data carries register bits
    assign rdata = {24'h00_0000, st.rData};
    assign rresp = st.rResp;
    assign periphEnableReg3 = st.enable3;
    assign reqHigh = st.reqHi;
    assign reqLow = st.reqLo;
    assign irq = st.irq;

endmodule : pie_irq_enable_priority

`default_nettype wire

/* bench/pie_irq_enable_priority_props.sv */
// Purpose: Port-level checks for the interrupt enable/priority block
// Assumes: Single clock mclk, synchronous active-high srst
// Notes: Bound to the top module, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module pie_irq_enable_priority_props #(
    parameter int ADDR_W = 8 // Address width
) (
    input wire logic mclk, // Clock
    input wire logic srst, // Reset
    input wire logic awvalid, // Aw valid
    input wire logic awready, // Aw ready
    input wire logic [ADDR_W-1:0] awaddr, // Aw address
    input wire logic wvalid, // W valid
    input wire logic wready, // W ready
    input wire logic [31:0] wdata, // W data
    input wire logic [3:0] wstrb, // W strobes
    input wire logic bvalid, // B valid
    input wire logic bready, // B ready
    input wire logic [1:0] bresp, // B response
    input wire logic arvalid, // Ar valid
    input wire logic arready, // Ar ready
    input wire logic [ADDR_W-1:0] araddr, // Ar address
    input wire logic rvalid, // R valid
    input wire logic rready, // R ready
    input wire logic [31:0] rdata, // R data
    input wire logic [1:0] rresp, // R response
    input wire logic [7:0] prio1SrcFlag, // Group 1 flags
    input wire logic [7:0] prio1SrcEn, // Group 1 enables
    input wire logic [7:0] prio2SrcFlag, // Group 2 flags
    input wire logic [7:0] prio2SrcEn, // Group 2 enables
    input wire logic [7:0] enable3SrcFlag, // Group 3 flags
    input wire logic [7:0] periphEnableReg3, // Enable register 3
    input wire logic reqHigh, // High vector request
    input wire logic reqLow, // Low vector request
    input wire logic irq // Summary interrupt
);
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    // Any source with flag and enable both set
    wire logic anyActive = |(enable3SrcFlag & periphEnableReg3) |
        |(prio1SrcFlag & prio1SrcEn) | |(prio2SrcFlag & prio2SrcEn);
    // Handshake steps
    sequence wrTaken; awvalid && awready && wvalid && wready; endsequence
    sequence rdTaken; arvalid && arready; endsequence
    a_en3_upper: assert property (periphEnableReg3[7:6] == 2'b00)
        else $error("enable 3 upper bits set");
    a_reset_clears: assert property (disable iff (1'b0) srst |=>
        periphEnableReg3 == 8'h00 && !reqHigh && !reqLow && !irq)
        else $error("outputs not cleared by reset");
    a_idle_quiet: assert property (!anyActive |=> !reqHigh && !reqLow)
        else $error("request without an enabled flag");
    a_src_requests: assert property (anyActive |=> reqHigh || reqLow)
        else $error("enabled flag gave no request");
    a_write_answer: assert property (wrTaken |-> ##[1:2] bvalid)
        else $error("write response late");
    a_read_answer: assert property (rdTaken |-> ##[1:2] rvalid)
        else $error("read data late");
    a_bresp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    a_rdata_holds: assert property (rvalid && !rready |=>
        rvalid && $stable(rdata) && $stable(rresp))
        else $error("read data dropped");
    a_rdata_upper: assert property (rvalid |-> rdata[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
    a_busy_refuse: assert property (bvalid |=> $stable(periphEnableReg3))
        else $error("enable register written while response pending");
    a_read_refuse: assert property (rvalid |-> !arready)
        else $error("read accepted while data pending");
    c_low_req: cover property (reqLow);
endmodule : pie_irq_enable_priority_props
////////////////////////////////////////////////////////////
bind pie_irq_enable_priority pie_irq_enable_priority_props #(.ADDR_W(ADDR_W)) u_props (
    .mclk(mclk), .srst(srst), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .prio1SrcFlag(prio1SrcFlag), .prio1SrcEn(prio1SrcEn), .prio2SrcFlag(prio2SrcFlag),
    .prio2SrcEn(prio2SrcEn), .enable3SrcFlag(enable3SrcFlag),
    .periphEnableReg3(periphEnableReg3), .reqHigh(reqHigh), .reqLow(reqLow), .irq(irq));
`default_nettype wire

/* bench/test_pie_irq_enable_priority.sv */
// Purpose: Self-checking bench for the interrupt enable/priority block
// Assumes: 50 MHz mclk, AXI4-Lite master tasks below
// Notes: Register rows first, then routing, interrupt and reset cases
`timescale 1ns/1ps
`default_nettype none
`define PIE_CHK(n, e, g) begin numChecks++; if ((g) !== (e)) begin nMismatch++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module test_pie_irq_enable_priority;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [1:0] rs; logic [7:0] rd;} pie_row_s;
    logic mclk, srst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0; // Bus drive
    logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, periphEnableReg3;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] bresp, rresp, rs;
    logic [7:0] prio1SrcFlag = 8'h00, prio1SrcEn = 8'h00, prio2SrcFlag = 8'h00;
    logic [7:0] prio2SrcEn = 8'h00, enable3SrcFlag = 8'h00, m;
    logic reqHigh, reqLow, irq;
    logic [31:0] rv;
    int nMismatch = 0, numChecks = 0;
    // Rows: address, write value, response, read-back (upper bits read zero)
    pie_row_s rows [8] = '{'{8'h00, 8'hFF, 2'h0, 8'h3F}, '{8'h04, 8'h5A, 2'h0, 8'h5A},
        '{8'h08, 8'hFF, 2'h0, 8'h5F}, '{8'h0C, 8'hFF, 2'h0, 8'h3F},
        '{8'h10, 8'hFF, 2'h0, 8'h03}, '{8'h18, 8'hFF, 2'h0, 8'h03},
        '{8'h1C, 8'hFF, 2'h0, 8'h00}, '{8'h20, 8'hFF, 2'h2, 8'h00}};
    logic [7:0] rstA [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
    logic [7:0] rstV [7] = '{8'h00, 8'hFF, 8'h5F, 8'h3F, 8'h00, 8'h00, 8'h00};
    pie_irq_enable_priority dut (.mclk(mclk), .srst(srst), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .prio1SrcFlag(prio1SrcFlag),
        .prio1SrcEn(prio1SrcEn), .prio2SrcFlag(prio2SrcFlag), .prio2SrcEn(prio2SrcEn),
        .enable3SrcFlag(enable3SrcFlag), .periphEnableReg3(periphEnableReg3),
        .reqHigh(reqHigh), .reqLow(reqLow), .irq(irq));
    ////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // Write: both channels offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
        logic awDone, wDone, awTake, wTake;
        @(posedge mclk);
        {awDone, wDone} = 2'b00;
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        wstrb <= 4'h1;
        {awvalid, wvalid, bready} <= 3'b111;
        // Readies are registered: mid-cycle values are those of the next edge
        while (!(awDone && wDone)) begin
            @(negedge mclk);
            awTake = !awDone && awready;
            wTake = !wDone && wready;
            @(posedge mclk);
            if (awTake) begin
                awDone = 1'b1;
                awvalid <= 1'b0;
            end
            if (wTake) begin
                wDone = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(negedge mclk); while (!bvalid);
        r = bresp;
        @(posedge mclk);
        bready <= 1'b0;
    endtask : wr
    // Read: address held until taken, rready held until data seen
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge mclk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do @(negedge mclk); while (!arready);
        @(posedge mclk);
        arvalid <= 1'b0;
        do @(negedge mclk); while (!rvalid);
        d = rdata;
        r = rresp;
        @(posedge mclk);
        rready <= 1'b0;
    endtask : rd
    // Drive sources, let the registered requests settle, compare
    task automatic route(input logic [7:0] f1, e1, f2, e2, f3, input logic h, l);
        @(posedge mclk);
        {prio1SrcFlag, prio1SrcEn, prio2SrcFlag, prio2SrcEn, enable3SrcFlag} <=
            {f1, e1, f2, e2, f3};
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        `PIE_CHK("reqHigh", h, reqHigh)
        `PIE_CHK("reqLow", l, reqLow)
    endtask : route
    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", numChecks, nMismatch);
        if (nMismatch == 0 && numChecks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude
    // Watchdog: far beyond the few hundred cycles the sequence needs
    initial begin
        #400000;
        nMismatch++;
        conclude();
    end
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d, rs);
            `PIE_CHK("bresp", rows[i].rs, rs)
            rd(rows[i].a, rv, rs);
            `PIE_CHK("rdata", {24'h00_0000, rows[i].rd}, rv)
            `PIE_CHK("rresp", rows[i].rs, rs)
        end
        wr(8'h10, 8'h00, rs);
        // Each enable bit gates only its own source, levels off goes high
        for (int b = 0; b < 6; b++) begin
            m = 8'h01 << b;
            wr(8'h00, m, rs);
            `PIE_CHK("periphEnableReg3", m, periphEnableReg3)
            route(8'h00, 8'h00, 8'h00, 8'h00, ~m, 1'b0, 1'b0);
            route(8'h00, 8'h00, 8'h00, 8'h00, m, 1'b1, 1'b0);
        end
        wr(8'h0C, 8'h00, rs);
        route(8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 1'b1, 1'b0);
        wr(8'h10, 8'h01, rs);
        route(8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 1'b0, 1'b1);
        // Priority 1 bit map, parport stays high outside mcu mode
        for (int b = 0; b < 8; b++) begin
            m = 8'h01 << b;
            wr(8'h04, ~m, rs);
            route(m, m, 8'h00, 8'h00, 8'h00, b == 7, b != 7);
        end
        wr(8'h10, 8'h03, rs);
        route(8'h80, 8'h80, 8'h00, 8'h00, 8'h00, 1'b0, 1'b1);
        route(8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 1'b0, 1'b0);
        wr(8'h08, 8'h00, rs);
        route(8'h00, 8'h00, 8'h40, 8'h40, 8'h00, 1'b0, 1'b1);
        // Interrupt: raise, mask, unmask, clear
        route(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
        wr(8'h14, 8'h03, rs);
        wr(8'h18, 8'h02, rs);
        route(8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 1'b0, 1'b1);
        `PIE_CHK("irq", 1'b1, irq)
        rd(8'h14, rv, rs);
        `PIE_CHK("status", 32'h0000_0002, rv)
        rd(8'h1C, rv, rs);
        `PIE_CHK("pending", 32'h0000_0002, rv)
        wr(8'h18, 8'h01, rs);
        `PIE_CHK("irq", 1'b0, irq)
        wr(8'h18, 8'h02, rs);
        `PIE_CHK("irq", 1'b1, irq)
        route(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
        wr(8'h14, 8'h02, rs);
        `PIE_CHK("irq", 1'b0, irq)
        // Mid-run reset brings back the reset values
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        `PIE_CHK("periphEnableReg3", 8'h00, periphEnableReg3)
        foreach (rstA[i]) begin
            rd(rstA[i], rv, rs);
            `PIE_CHK("reset value", {24'h00_0000, rstV[i]}, rv)
        end
        conclude();
    end
endmodule : test_pie_irq_enable_priority
`default_nettype wire
